// file: rtl/dcp_pin_config.sv
// Port 4 routing, enable registers and chip selects for two CAN controllers.
// Assumes CAN and two-wire signals come from logic on CLK; pins are outside.
module dcp_pin_config (
    input  wire logic              CLK,
    input  wire logic              RST,
    input  wire logic              CE,
    input  wire logic              PEN_WR,
    input  wire dcp_pkg::dcp_pen_t PEN_WDATA,
    input  wire logic              SYS_WR,
    input  wire logic              SYS_EXT_PERIPH_GLOBAL_ENABLE,
    input  wire logic              MISC_WR,
    input  wire logic              MISC_CAN_PARALLEL_ROUTE_BIT,
    input  wire logic [3:0]        P4_DATA,
    input  wire logic [3:0]        P4_DIR,
    input  wire logic [3:0]        P4_OD,
    input  wire logic [23:0]       ADDR,
    input  wire logic              ADDR_SEL,
    input  wire logic              CAN_A_TX,
    input  wire logic              CAN_B_TX,
    input  wire logic [3:0]        CAN_A_IRQ,
    input  wire logic [3:0]        CAN_B_IRQ,
    input  wire logic [3:0]        XP_IRQ,
    input  wire logic              TW_SCL_LOW,
    input  wire logic              TW_SDA_LOW,
    input  wire logic [3:0]        P4_IN,
    output logic [3:0]             P4_OUT,
    output logic [3:0]             P4_OE,
    output logic                   CAN_A_RX,
    output logic                   CAN_B_RX,
    output logic                   TW_SCL_IN,
    output logic                   TW_SDA_IN,
    output logic                   CS_A,
    output logic                   CS_B,
    output logic [3:0]             XBUS_IRQ,
    output dcp_pkg::dcp_pen_t      PEN_Q,
    output logic                   EXT_PERIPH_GLOBAL_ENABLE_Q,
    output logic                   CAN_PAR,
    output logic [3:0]             SEG_ADDR_LINES,
    output logic [6:0]             MSG_OBJ_CAP,
    output logic [1:0]             FRAME_FMT
);

    // ============================================================
    // Helpers

    // Pin drive as {out, oe}; open-drain only pulls low, the wire floats high.
    function automatic logic [1:0] drive(input logic lvl, input logic od);
        drive = od ? {1'b0, ~lvl} : {lvl, 1'b1};
    endfunction

    function automatic logic [1:0] gpio(input logic d, input logic dir,
                                        input logic od);
        gpio = dir ? drive(d, od) : 2'h0;
    endfunction

    function automatic logic in_win(input logic [23:0] a, input logic hi);
        in_win = (a[23:dcp_pkg::WIN_LSB] == dcp_pkg::CAN_A_BASE[23:dcp_pkg::WIN_LSB])
              && (a[dcp_pkg::SEL_BIT] == hi);
    endfunction

    dcp_pkg::dcp_state_t s_q;
    dcp_pkg::dcp_state_t s_d;

    logic       a_act;
    logic       b_act;
    logic       par;
    logic       tw;
    logic       misc_ok;
    logic       wired_tx;
    logic [1:0] pd [4];

    // The CAN enables only take effect behind the global enable, so a
    // controller switched on before the global enable still sees a clean start.
    assign a_act    = s_q.pen.can_a_en && s_q.ext_periph_global_enable;
    assign b_act    = s_q.pen.can_b_en && s_q.ext_periph_global_enable;
    assign par      = s_q.can_parallel_route_bit;
    assign tw       = s_q.pen.tw_en;
    assign misc_ok  = s_q.pen.misc_acc && s_q.ext_periph_global_enable;
    assign wired_tx = (a_act ? CAN_A_TX : 1'b1) & (b_act ? CAN_B_TX : 1'b1);

    // ============================================================
    // Pin routing
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pd[i] = gpio(P4_DATA[i], P4_DIR[i], P4_OD[i]);
        end
        if (par) begin
            if (a_act || b_act) begin
                pd[dcp_pkg::PIN_A_TX] = drive(wired_tx, P4_OD[dcp_pkg::PIN_A_TX]);
                pd[dcp_pkg::PIN_A_RX] = 2'h0;
            end
        end else begin
            if (a_act) begin
                pd[dcp_pkg::PIN_A_TX] = drive(CAN_A_TX, P4_OD[dcp_pkg::PIN_A_TX]);
                pd[dcp_pkg::PIN_A_RX] = 2'h0;
            end
            if (b_act) begin
                pd[dcp_pkg::PIN_B_TX] = drive(CAN_B_TX, P4_OD[dcp_pkg::PIN_B_TX]);
                pd[dcp_pkg::PIN_B_RX] = 2'h0;
            end
        end
        // The two-wire module overrides port and CAN control of bits 4 and 7.
        if (tw) begin
            pd[dcp_pkg::PIN_B_RX] = {1'b0, TW_SCL_LOW};
            pd[dcp_pkg::PIN_B_TX] = {1'b0, TW_SDA_LOW};
        end
    end

    // ============================================================
    // Next state
    always_comb begin
        s_d = s_q;
        if (PEN_WR) begin
            s_d.pen = PEN_WDATA;
        end
        if (SYS_WR) begin
            s_d.ext_periph_global_enable = SYS_EXT_PERIPH_GLOBAL_ENABLE;
        end
        if (MISC_WR && misc_ok) begin
            s_d.can_parallel_route_bit = MISC_CAN_PARALLEL_ROUTE_BIT;
        end
        s_d.sync1 = P4_IN;
        s_d.sync2 = s_q.sync1;
        for (int i = 0; i < 4; i++) begin
            s_d.pin_out[i] = pd[i][1];
            s_d.pin_oe[i]  = pd[i][0];
        end
        if (par) begin
            s_d.rx_a = s_q.sync2[dcp_pkg::PIN_A_RX];
            s_d.rx_b = s_q.sync2[dcp_pkg::PIN_A_RX];
        end else begin
            s_d.rx_a = s_q.sync2[dcp_pkg::PIN_A_RX];
            s_d.rx_b = s_q.sync2[dcp_pkg::PIN_B_RX];
        end
        s_d.cs_a = ADDR_SEL && a_act && in_win(ADDR, 1'b0);
        s_d.cs_b = ADDR_SEL && b_act && in_win(ADDR, 1'b1);
        s_d.irq  = XP_IRQ | (a_act ? CAN_A_IRQ : 4'h0)
                 | (b_act ? CAN_B_IRQ : 4'h0);
    end

    // ============================================================
    // State register; reset wins over the clock enable.
    always_ff @(posedge CLK) begin
        if (RST) begin
            s_q        <= '0;
            s_q.pen    <= dcp_pkg::PEN_RESET;
            s_q.sync1  <= 4'hF;
            s_q.sync2  <= 4'hF;
            s_q.rx_a   <= 1'b1;
            s_q.rx_b   <= 1'b1;
        end else if (CE) begin
            s_q <= s_d;
        end
    end

    // ============================================================
    // Outputs
    assign P4_OUT    = s_q.pin_out;
    assign P4_OE     = s_q.pin_oe;
    assign CAN_A_RX  = s_q.rx_a;
    assign CAN_B_RX  = s_q.rx_b;
    assign TW_SCL_IN = s_q.sync2[dcp_pkg::PIN_B_RX];
    assign TW_SDA_IN = s_q.sync2[dcp_pkg::PIN_B_TX];
    assign CS_A      = s_q.cs_a;
    assign CS_B      = s_q.cs_b;
    assign XBUS_IRQ  = s_q.irq;
    assign PEN_Q     = s_q.pen;
    assign EXT_PERIPH_GLOBAL_ENABLE_Q    = s_q.ext_periph_global_enable;
    assign CAN_PAR   = s_q.can_parallel_route_bit;

    // Fewer segment lines with CAN on, since bits 4..7 serve as CAN pins.
    assign SEG_ADDR_LINES = (a_act || b_act) ? dcp_pkg::SEG_LINES_CAN
                                             : dcp_pkg::SEG_LINES_ALL;
    assign MSG_OBJ_CAP = (a_act ? dcp_pkg::OBJ_PER_CAN : 7'h00)
                       + (b_act ? dcp_pkg::OBJ_PER_CAN : 7'h00);
    // Bit 0 standard 11-bit, bit 1 extended 29-bit identifiers.
    assign FRAME_FMT = {2{a_act || b_act}};

    // ============================================================
    // Checks
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    a_cs_split: assert property (
        CE && ADDR_SEL && a_act && in_win(ADDR, 1'b0) |=> CS_A && !CS_B)
        else $error("CAN A select not decoded alone");

    a_pin_a_tx: assert property (
        CE && a_act && !par |=>
        (P4_OE[dcp_pkg::PIN_A_TX] ? P4_OUT[dcp_pkg::PIN_A_TX] : 1'b1) == $past(CAN_A_TX))
        else $error("CAN A transmit level not on bit 6");

    a_pin_b_tx: assert property (
        CE && b_act && !par && !tw |=>
        (P4_OE[dcp_pkg::PIN_B_TX] ? P4_OUT[dcp_pkg::PIN_B_TX] : 1'b1) == $past(CAN_B_TX))
        else $error("CAN B transmit level not on bit 7");

    a_irq_merge: assert property (
        CE && !a_act && !b_act && $stable(s_q.ext_periph_global_enable) |=> XBUS_IRQ == $past(XP_IRQ))
        else $error("Disabled CAN interrupt leaked onto shared lines");

    a_reset_pen: assert property (
        $past(RST) |-> PEN_Q == dcp_pkg::PEN_RESET && !EXT_PERIPH_GLOBAL_ENABLE_Q)
        else $error("Enable register not at reset value");

    a_seg_lines: assert property (
        CE && PEN_WR && PEN_WDATA.can_b_en && s_q.ext_periph_global_enable && !SYS_WR |=>
        SEG_ADDR_LINES == dcp_pkg::SEG_LINES_CAN)
        else $error("Segment lines not limited with CAN on");

    a_obj_cap: assert property (
        a_act && b_act |-> MSG_OBJ_CAP == 7'h40)
        else $error("Shared bus capacity not 64 objects");

    a_misc_lock: assert property (
        CE && MISC_WR && !misc_ok |=> CAN_PAR == $past(CAN_PAR))
        else $error("Misc register written while locked");

    a_tw_pins: assert property (
        CE && tw |=> !P4_OUT[dcp_pkg::PIN_B_RX] && !P4_OUT[dcp_pkg::PIN_B_TX])
        else $error("Two-wire pins driven high");

    a_od_tx: assert property (
        CE && a_act && !par && P4_OD[dcp_pkg::PIN_A_TX] |=> !P4_OUT[dcp_pkg::PIN_A_TX])
        else $error("Open-drain transmit drove high");

    a_par_rx: assert property (
        CE && par ##1 CE && par |=> CAN_A_RX == CAN_B_RX)
        else $error("Parallel receive not shared");

    a_par_free: assert property (
        CE && par && !tw && !P4_DIR[dcp_pkg::PIN_B_TX] |=> !P4_OE[dcp_pkg::PIN_B_TX])
        else $error("Bit 7 not freed in parallel mode");

    a_cs_b_split: assert property (
        CE && ADDR_SEL && b_act && in_win(ADDR, 1'b1) |=> CS_B && !CS_A)
        else $error("CAN B select not decoded alone");

    a_cs_idle: assert property (
        CE && !ADDR_SEL |=> !CS_A && !CS_B)
        else $error("Chip select raised without an access");

    a_rx_a_route: assert property (
        CE && a_act && !par |=>
        CAN_A_RX == $past(s_q.sync2[dcp_pkg::PIN_A_RX]))
        else $error("CAN A receive not taken from bit 5");

    a_rx_b_route: assert property (
        CE && b_act && !par |=>
        CAN_B_RX == $past(s_q.sync2[dcp_pkg::PIN_B_RX]))
        else $error("CAN B receive not taken from bit 4");

    a_irq_active: assert property (
        CE && a_act && b_act |=>
        XBUS_IRQ == ($past(XP_IRQ) | $past(CAN_A_IRQ) | $past(CAN_B_IRQ)))
        else $error("Active CAN interrupts not merged");

    a_ce_freeze: assert property (
        !CE |=> $stable(PEN_Q) && $stable(EXT_PERIPH_GLOBAL_ENABLE_Q) && $stable(CAN_PAR))
        else $error("Enable state changed while clock enable low");

    a_seg_all: assert property (
        !a_act && !b_act |-> SEG_ADDR_LINES == dcp_pkg::SEG_LINES_ALL)
        else $error("Segment lines limited with no CAN active");

    a_obj_none: assert property (
        !a_act && !b_act |-> MSG_OBJ_CAP == 7'h00)
        else $error("Message capacity reported with no CAN active");

    a_od_b_tx: assert property (
        CE && b_act && !par && !tw && P4_OD[dcp_pkg::PIN_B_TX] |=>
        !P4_OUT[dcp_pkg::PIN_B_TX])
        else $error("Open-drain CAN B transmit drove high");

    a_par_tx: assert property (
        CE && par && a_act && b_act && !P4_OD[dcp_pkg::PIN_A_TX] |=>
        P4_OUT[dcp_pkg::PIN_A_TX] == ($past(CAN_A_TX) && $past(CAN_B_TX)))
        else $error("Shared transmit pin not wire-ANDed");

    a_par_rx_off: assert property (
        CE && par && (a_act || b_act) |=> !P4_OE[dcp_pkg::PIN_A_RX])
        else $error("Shared receive pin driven in parallel mode");

    a_frame_fmt: assert property (
        (a_act || b_act) |-> FRAME_FMT == 2'h3)
        else $error("Frame formats not both offered");

    a_gpio_back: assert property (
        CE && !tw && par && P4_DIR[dcp_pkg::PIN_B_RX] && !P4_OD[dcp_pkg::PIN_B_RX] |=>
        P4_OE[dcp_pkg::PIN_B_RX] &&
        P4_OUT[dcp_pkg::PIN_B_RX] == $past(P4_DATA[dcp_pkg::PIN_B_RX]))
        else $error("Bit 4 not under port control");

    a_tw_oe: assert property (
        CE && tw |=> P4_OE[dcp_pkg::PIN_B_RX] == $past(TW_SCL_LOW) &&
        P4_OE[dcp_pkg::PIN_B_TX] == $past(TW_SDA_LOW))
        else $error("Two-wire enables not following the module");

    a_misc_open: assert property (
        CE && MISC_WR && misc_ok |=> CAN_PAR == $past(MISC_CAN_PARALLEL_ROUTE_BIT))
        else $error("Misc register write lost while open");

    a_reset_pins: assert property (
        $past(RST) |-> P4_OE == 4'h0 && CAN_A_RX && CAN_B_RX && !CS_A && !CS_B)
        else $error("Pins or selects not at reset state");

endmodule // dcp_pin_config

// file: shared/dcp_pkg.sv
// Constants and carrier types for the dual CAN pin and configuration block.
// Assumes one system clock with a synchronous active-high reset.
package dcp_pkg;

    // ============================================================
    // Address map
    localparam logic [23:0] CAN_A_BASE   = 24'hEF0000;
    localparam int          WIN_LSB      = 9;
    localparam int          SEL_BIT      = 8;

    // ============================================================
    // Pin slots: slot index n is port 4 bit n+4
    localparam int PIN_B_RX = 0;
    localparam int PIN_A_RX = 1;
    localparam int PIN_A_TX = 2;
    localparam int PIN_B_TX = 3;

    // ============================================================
    // Capacity figures
    localparam logic [3:0] SEG_LINES_ALL = 4'h8;
    localparam logic [3:0] SEG_LINES_CAN = 4'h4;
    localparam logic [6:0] OBJ_PER_CAN   = 7'h20;

    // ============================================================
    // Peripheral-enable register layout
    typedef struct packed {
        logic misc_acc;
        logic tw_en;
        logic can_b_en;
        logic can_a_en;
    } dcp_pen_t;

    localparam dcp_pen_t PEN_RESET = 4'h1;

    typedef struct packed {
        dcp_pen_t   pen;
        logic       ext_periph_global_enable;
        logic       can_parallel_route_bit;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic [3:0] pin_out;
        logic [3:0] pin_oe;
        logic       rx_a;
        logic       rx_b;
        logic       cs_a;
        logic       cs_b;
        logic [3:0] irq;
    } dcp_state_t;

endpackage

// file: testbench/dcp_can_xcvr.sv
// CAN transceiver model on port 4 bits 7..4 (index 0 is bit 4).
// Assumes pull-ups on all four pins and device drive as output plus enable.
module dcp_can_xcvr (
    input  wire logic [3:0] p4_out,
    input  wire logic [3:0] p4_oe,
    input  wire logic [1:0] bus_dom,
    output logic [3:0]      pin,
    output logic [3:0]      p4_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // ============================================================
    // Pin levels and bus echo
    // A released pin reads the pull-up level, never its last driven value.
    assign pin = (p4_oe & p4_out) | ~p4_oe;
    // Each transceiver echoes its transmit pin; another node may force dominant.
    assign p4_in = {pin[3:2], pin[2] & ~bus_dom[0] & pin[1], pin[3] & ~bus_dom[1] & pin[0]};
endmodule // dcp_can_xcvr

// file: testbench/dual_can_pin_config_tb_top.sv
// Self-checking bench for the dual CAN pin and configuration block.
// Assumes the package, the design and the transceiver model are compiled first.
module dual_can_pin_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, pen_wr = 1'b0, sys_wr = 1'b0, misc_wr = 1'b0;
    logic ext_periph_global_enable = 1'b0, can_parallel_route_bit = 1'b0, asel = 1'b0, tx_a = 1'b1, tx_b = 1'b1;
    logic scl_low = 1'b0, sda_low = 1'b0, rx_a, rx_b, cs_a, cs_b, ext_periph_global_enable_q, can_par;
    logic ce = 1'b1, tw_scl_in, tw_sda_in;
    logic [3:0]  p_data = 4'h0, p_dir = 4'h0, p_od = 4'h0, irq_a = 4'h0;
    logic [3:0]  irq_b = 4'h0, irq_x = 4'h0, p_in, p_out, p_oe, pin, xbus, seg;
    logic [1:0]  dom = 2'h0, fmt;
    logic [6:0]  cap;
    logic [23:0] addr = 24'h000000;
    dcp_pkg::dcp_pen_t wdata = 4'h0, pen_q;
    int fail_count = 0, checks_done = 0, cycles = 0;

    dcp_pin_config dut_u (.CLK(clk), .RST(rst), .CE(ce), .PEN_WR(pen_wr),
        .PEN_WDATA(wdata), .SYS_WR(sys_wr), .SYS_EXT_PERIPH_GLOBAL_ENABLE(ext_periph_global_enable), .MISC_WR(misc_wr),
        .MISC_CAN_PARALLEL_ROUTE_BIT(can_parallel_route_bit), .P4_DATA(p_data), .P4_DIR(p_dir), .P4_OD(p_od),
        .ADDR(addr), .ADDR_SEL(asel), .CAN_A_TX(tx_a), .CAN_B_TX(tx_b),
        .CAN_A_IRQ(irq_a), .CAN_B_IRQ(irq_b), .XP_IRQ(irq_x), .TW_SCL_LOW(scl_low),
        .TW_SDA_LOW(sda_low), .P4_IN(p_in), .P4_OUT(p_out), .P4_OE(p_oe),
        .CAN_A_RX(rx_a), .CAN_B_RX(rx_b), .TW_SCL_IN(tw_scl_in), .TW_SDA_IN(tw_sda_in),
        .CS_A(cs_a), .CS_B(cs_b), .XBUS_IRQ(xbus), .PEN_Q(pen_q), .EXT_PERIPH_GLOBAL_ENABLE_Q(ext_periph_global_enable_q),
        .CAN_PAR(can_par), .SEG_ADDR_LINES(seg), .MSG_OBJ_CAP(cap), .FRAME_FMT(fmt));
    dcp_can_xcvr xcvr_u (.p4_out(p_out), .p4_oe(p_oe), .bus_dom(dom), .pin(pin),
        .p4_in(p_in));

    always #12.5 clk = ~clk;

    // ============================================================
    // Shared tasks
    task automatic complete_run();
        $display("Checks %0d, mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Strobes rise for exactly one cycle, so back-to-back writes never overlap.
    task automatic wr(input logic [2:0] sel, input logic [3:0] d);
        @(posedge clk);
        {misc_wr, sys_wr, pen_wr} <= sel;
        wdata <= dcp_pkg::dcp_pen_t'(d);
        {ext_periph_global_enable, can_parallel_route_bit} <= {d[0], d[0]};
        @(posedge clk);
        {misc_wr, sys_wr, pen_wr} <= 3'h0;
        #1;
    endtask
    task automatic rnd(input logic [11:0] mask);
        @(posedge clk);
        {tx_a, tx_b, dom, scl_low, sda_low} <= 6'($urandom());
        {p_od, p_dir, p_data} <= 12'($urandom()) & mask;
        {irq_a, irq_b, irq_x} <= 12'($urandom());
    endtask
    function automatic logic gpio(input logic dir, input logic d);
        return dir ? d : 1'b1;
    endfunction

    always @(posedge clk) begin
        cycles++;
        if (cycles == 5000) begin
            fail_count++;
            complete_run();
        end
    end

    // ============================================================
    // Test sequence
    initial begin
        void'($urandom(62319));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        wt(1);
        chk("pen_q", pen_q, dcp_pkg::PEN_RESET);
        chk("ext_periph_global_enable_q", {ext_periph_global_enable_q, can_par}, 2'h0);
        $display("Test reset done");
        wr(3'h1, 4'h3);
        wr(3'h2, 4'h1);
        chk("pen_q", {pen_q, ext_periph_global_enable_q}, 5'h07);
        for (int i = 0; i < 24; i++) begin
            rnd(12'hF0F);
            asel <= 1'b1;
            addr <= (i % 4 == 3) ? 24'($urandom()) :
                {dcp_pkg::CAN_A_BASE[23:9], 9'($urandom())};
            wt(6);
            chk("cs", {cs_a, cs_b}, (addr[23:9] == dcp_pkg::CAN_A_BASE[23:9]) ?
                {~addr[8], addr[8]} : 2'h0);
            chk("pin_a_tx", pin[2], tx_a);
            chk("pin_b_tx", pin[3], tx_b);
            if (p_od[2]) chk("od_a", {p_out[2], p_oe[2]}, {1'b0, ~tx_a});
            if (p_od[3]) chk("od_b", {p_out[3], p_oe[3]}, {1'b0, ~tx_b});
            chk("rx_a", rx_a, tx_a & ~dom[0]);
            chk("rx_b", rx_b, tx_b & ~dom[1]);
            chk("irq", xbus, irq_x | irq_a | irq_b);
            chk("seg", seg, dcp_pkg::SEG_LINES_CAN);
            chk("cap", cap, 2 * dcp_pkg::OBJ_PER_CAN);
            chk("fmt", fmt, 2'h3);
        end
        $display("Test routing done");
        wr(3'h4, 4'h1);
        chk("par_refused", can_par, 1'b0);
        wr(3'h1, 4'hB);
        wr(3'h4, 4'h1);
        chk("par_set", can_par, 1'b1);
        for (int i = 0; i < 12; i++) begin
            rnd(12'h0FF);
            wt(6);
            chk("par_tx", pin[2], tx_a & tx_b);
            chk("par_rx", {rx_a, rx_b}, {2{tx_a & tx_b & ~dom[0]}});
            chk("free7", pin[3], gpio(p_dir[3], p_data[3]));
            chk("free4", pin[0], gpio(p_dir[0], p_data[0]));
        end
        $display("Test parallel done");
        wr(3'h1, 4'hF);
        for (int i = 0; i < 8; i++) begin
            rnd(12'hFFF);
            wt(3);
            chk("tw_scl", {p_out[0], p_oe[0]}, {1'b0, scl_low});
            chk("tw_scl_in", tw_scl_in, p_in[0]);
            chk("tw_sda_in", tw_sda_in, p_in[3]);
            chk("tw_sda", {p_out[3], p_oe[3]}, {1'b0, sda_low});
        end
        wr(3'h1, 4'hB);
        rnd(12'h0FF);
        wt(3);
        chk("gpio4", pin[0], gpio(p_dir[0], p_data[0]));
        $display("Test two-wire done");
        wr(3'h1, 4'h0);
        wt(1);
        chk("seg_all", seg, dcp_pkg::SEG_LINES_ALL);
        chk("cap_none", cap, 7'h00);
        chk("fmt_none", fmt, 2'h0);
        chk("cs_off", {cs_a, cs_b}, 2'h0);
        @(posedge clk);
        ce <= 1'b0;
        wr(3'h1, 4'h3);
        chk("ce_hold", pen_q, 4'h0);
        @(posedge clk);
        ce <= 1'b1;
        $display("Test disable done");
        complete_run();
    end
endmodule // dual_can_pin_config_tb_top
